// ---- pkg/status_input_pkg.sv ----
package status_input_pkg;

    // Channel count: the status input is evaluated per channel.
    localparam int unsigned NUM_CHANNELS = 2;
    localparam int unsigned CHAN_W = 1;

    // Diagnostic text identifier for status-input overvoltage.
    localparam logic [15:0] DIAG_TEXT_OVERVOLT = 16'h8315;

    // Diagnostic message types.
    localparam logic [1:0] DIAG_TYPE_INFO = 2'h0;
    localparam logic [1:0] DIAG_TYPE_WARN = 2'h1;
    localparam logic [1:0] DIAG_TYPE_ERROR = 2'h2;

    // Reset values of the flags and LED.
    localparam logic STATUS_OK_RESET = 1'b1;
    localparam logic ERROR_FLAG_RESET = 1'b0;
    localparam logic LED_RESET = 1'b0;

    // LED colour codes.
    typedef enum logic [1:0] {
        LED_OFF = 2'h0,
        LED_RED = 2'h1
    } led_state_t;

    // Overvoltage tracking state, one-hot.
    typedef enum logic [1:0] {
        OV_IDLE = 2'b01,
        OV_ACTIVE = 2'b10
    } ov_state_t;

endpackage

// ---- pkg/diag_event_if.sv ----
`timescale 1ns/1ns
// Carries one diagnostic event from a channel to the diagnostic formatter.
interface diag_event_if;
    import status_input_pkg::*;
    logic raise;
    logic [CHAN_W-1:0] channel;

    modport source (output raise, output channel);
    modport sink (input raise, input channel);
endinterface

// ---- logic/diag_record_former.sv ----
`timescale 1ns/1ns
module diag_record_former (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Event from the channel logic.
    diag_event_if.sink evt,
    // Diagnostic record out.
    output logic diag_valid,
    output logic [1:0] diag_type,
    output logic [15:0] diag_text_id,
    output logic [status_input_pkg::CHAN_W-1:0] diag_channel
);
    import status_input_pkg::*;

    logic valid_reg, valid_next;
    logic [1:0] type_reg, type_next;
    logic [15:0] text_reg, text_next;
    logic [CHAN_W-1:0] chan_reg, chan_next;

    // Each cycle with an overvoltage onset becomes one error-type record lasting one cycle.
    always_comb begin
        valid_next = evt.raise;
        type_next = type_reg;
        text_next = text_reg;
        chan_next = chan_reg;
        if (evt.raise) begin
            type_next = DIAG_TYPE_ERROR;
            text_next = DIAG_TEXT_OVERVOLT;
            chan_next = evt.channel;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_reg <= 1'b0;
            type_reg <= DIAG_TYPE_INFO;
            text_reg <= 16'h0000;
            chan_reg <= '0;
        end else begin
            valid_reg <= valid_next;
            type_reg <= type_next;
            text_reg <= text_next;
            chan_reg <= chan_next;
        end
    end

    assign diag_valid = valid_reg;
    assign diag_type = type_reg;
    assign diag_text_id = text_reg;
    assign diag_channel = chan_reg;
endmodule

// ---- logic/encoder_fault_status_input.sv ----
`timescale 1ns/1ns
// What this block does
// - The status input is only evaluated while the channel is in single-channel mode.
// - A high or open status input gives a TRUE status flag and, without overvoltage, an unlit LED.
// - A low status input gives a FALSE status flag and a red LED.
// - Overvoltage on a channel's status input sets that channel's error flag.
// - Overvoltage onset emits an error-type diagnostic record with the overvoltage text id; of onsets in the same cycle, only the lowest channel's.
// - Overvoltage lights the channel's status LED red.
module encoder_fault_status_input #(
    parameter int unsigned CHANNELS = status_input_pkg::NUM_CHANNELS
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Configuration.
    input wire logic [CHANNELS-1:0] single_channel_mode,
    // Status input pins and comparators.
    input wire logic [CHANNELS-1:0] status_pin,
    input wire logic [CHANNELS-1:0] overvoltage_detect,
    // Status outputs.
    output logic [CHANNELS-1:0] status_ok,
    output logic [CHANNELS-1:0] status_error,
    output logic [CHANNELS-1:0] status_led_red,
    // Diagnostic record.
    output logic diagnostic_event_record_valid,
    output logic [1:0] diagnostic_event_record_type,
    output logic [15:0] diagnostic_event_record_text_id,
    output logic [status_input_pkg::CHAN_W-1:0] diagnostic_event_record_channel
);
    import status_input_pkg::*;

    // The diagnostic record names the channel in a field sized by the package; more
    // channels than that field can name would make two channels share one record.
    // Refuse such a build rather than report the wrong channel.
    if (CHANNELS < 1 || CHANNELS > (1 << CHAN_W)) begin : g_bad_channels
        $error("CHANNELS out of range for diagnostic channel field");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release.
    logic rst_meta_reg, rst_sync_reg;

    // Asynchronous assert, synchronous release, so no flop leaves reset half a cycle apart.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Evaluation helpers.
    // Every channel uses the same small functions, so the channels cannot drift apart
    // when one of them is changed.

    // The LED is red for a faulty encoder and for overvoltage alike, so an operator looking
    // at the LED alone cannot tell the two apart; the flags do that.
    function automatic logic led_red_of(input logic pin_level, input logic over_v);
        return over_v | ~pin_level;
    endfunction

    // An onset is overvoltage seen while the tracker is still idle, which limits the
    // diagnostic records to one per overvoltage episode.
    function automatic logic is_onset(input ov_state_t state, input logic over_v);
        return (state == OV_IDLE) && over_v;
    endfunction

    // One step of the tracker: idle until overvoltage appears, active until it drops.
    // The tracker needs one sampled cycle without overvoltage before it re-arms.
    function automatic ov_state_t ov_step(input ov_state_t state, input logic over_v);
        ov_state_t nxt;
        nxt = state;
        case (state)
            OV_IDLE: begin
                if (over_v) begin
                    nxt = OV_ACTIVE;
                end
            end
            OV_ACTIVE: begin
                if (!over_v) begin
                    nxt = OV_IDLE;
                end
            end
            // An illegal code falls back to idle and may report one spurious onset.
            default: nxt = OV_IDLE;
        endcase
        return nxt;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Status flag.
    logic [CHANNELS-1:0] ok_reg, ok_next;

    // An open line reads high through the pull-up, so only a line actively pulled low
    // reads FALSE; a broken wire therefore looks like a healthy encoder.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (single_channel_mode[i]) begin
                ok_next[i] = status_pin[i];
            end else begin
                ok_next[i] = STATUS_OK_RESET;
            end
        end
    end

    // The flag register only holds what the comb process computed.
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ok_reg <= {CHANNELS{STATUS_OK_RESET}};
        end else begin
            ok_reg <= ok_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overvoltage tracking and error flag.
    logic [CHANNELS-1:0] err_reg, err_next;
    ov_state_t ov_reg [CHANNELS];
    ov_state_t ov_next [CHANNELS];
    // One onset pulse per channel, combinational, read by the event selection below.
    logic [CHANNELS-1:0] onset;

    // The tracker turns a level into one event per onset; the error flag follows the
    // comparator itself, so it clears in the first cycle without overvoltage.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (single_channel_mode[i]) begin
                onset[i] = is_onset(ov_reg[i], overvoltage_detect[i]);
                ov_next[i] = ov_step(ov_reg[i], overvoltage_detect[i]);
                err_next[i] = overvoltage_detect[i];
            end else begin
                // Leaving the mode re-arms the tracker, so a channel that is enabled while
                // overvoltage stands reports it once.
                onset[i] = 1'b0;
                ov_next[i] = OV_IDLE;
                err_next[i] = ERROR_FLAG_RESET;
            end
        end
    end

    // Tracker state and error flag are registered together; no logic here.
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            err_reg <= {CHANNELS{ERROR_FLAG_RESET}};
            for (int i = 0; i < CHANNELS; i++) begin
                ov_reg[i] <= OV_IDLE;
            end
        end else begin
            err_reg <= err_next;
            for (int i = 0; i < CHANNELS; i++) begin
                ov_reg[i] <= ov_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status indicator LED.
    logic [CHANNELS-1:0] led_reg, led_next;

    // Overvoltage takes the LED red even with a healthy level, and it returns to the
    // level's picture in the cycle the overvoltage is gone.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (single_channel_mode[i]) begin
                led_next[i] = led_red_of(status_pin[i], overvoltage_detect[i]);
            end else begin
                led_next[i] = LED_RESET;
            end
        end
    end

    // The LED register only holds what the comb process computed.
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            led_reg <= {CHANNELS{LED_RESET}};
        end else begin
            led_reg <= led_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs.

    // Every output comes straight from a flip-flop, so a glitch on an input pin
    // never reaches an output between clock edges.
    assign status_ok = ok_reg;
    assign status_error = err_reg;
    assign status_led_red = led_reg;

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic event selection.
    diag_event_if evt_bus ();

    // Lowest channel wins on simultaneous onsets; a second onset in the same cycle
    // is not reported, a limitation accepted for a rare coincidence.
    always_comb begin
        evt_bus.raise = |onset;
        evt_bus.channel = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (onset[i]) begin
                evt_bus.channel = CHAN_W'(i);
            end
        end
    end

    // The record former registers the event once, so a record appears in the same cycle
    // as the error flag that it reports; its type, text and channel then hold until the
    // next onset.
    diag_record_former u_diag (
        .clk(core_clk),
        .rst_n(rst_sync_reg),
        .evt(evt_bus.sink),
        .diag_valid(diagnostic_event_record_valid),
        .diag_type(diagnostic_event_record_type),
        .diag_text_id(diagnostic_event_record_text_id),
        .diag_channel(diagnostic_event_record_channel)
    );
endmodule

// ---- tb/encoder_fault_status_input_asserts.sv ----
`timescale 1ns/1ns
module encoder_fault_status_input_asserts
    import status_input_pkg::*;
#(
    parameter int unsigned CHANNELS = 2
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Inputs.
    input wire logic [CHANNELS-1:0] single_channel_mode,
    input wire logic [CHANNELS-1:0] status_pin,
    input wire logic [CHANNELS-1:0] overvoltage_detect,
    // Outputs.
    input wire logic [CHANNELS-1:0] status_ok,
    input wire logic [CHANNELS-1:0] status_error,
    input wire logic [CHANNELS-1:0] status_led_red,
    input wire logic diagnostic_event_record_valid,
    input wire logic [1:0] diagnostic_event_record_type,
    input wire logic [15:0] diagnostic_event_record_text_id,
    input wire logic [CHAN_W-1:0] diagnostic_event_record_channel
);
    // The design releases its reset two edges after the pin and only then takes its first
    // sample, so every check waits until one edge past that sample has been seen.
    logic [2:0] settle_cnt;

    // Saturating count of edges since the reset pin was released.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_cnt <= 3'h0;
        end else if (settle_cnt != 3'h4) begin
            settle_cnt <= settle_cnt + 3'h1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n || settle_cnt != 3'h4);
    property p_ok;
        1 |=> status_ok == ($past(status_pin) | ~$past(single_channel_mode));
    endproperty
    property p_err;
        1 |=> status_error == ($past(overvoltage_detect) & $past(single_channel_mode));
    endproperty
    property p_led;
        1 |=> status_led_red == ($past(single_channel_mode)
            & ($past(overvoltage_detect) | ~$past(status_pin)));
    endproperty
    property p_onset1;
        $rose(overvoltage_detect[1]) && single_channel_mode[1] && !overvoltage_detect[0]
            |-> ##1 diagnostic_event_record_valid && diagnostic_event_record_channel == 1'h1;
    endproperty
    property p_onset0;
        $rose(overvoltage_detect[0]) && single_channel_mode[0]
            |-> ##1 diagnostic_event_record_valid && diagnostic_event_record_channel == 1'h0;
    endproperty
    property p_fields;
        diagnostic_event_record_valid |-> diagnostic_event_record_type == DIAG_TYPE_ERROR
            && diagnostic_event_record_text_id == DIAG_TEXT_OVERVOLT;
    endproperty
    property p_src;
        diagnostic_event_record_valid |-> ($past(overvoltage_detect) & $past(single_channel_mode)
            & ~($past(overvoltage_detect, 2) & $past(single_channel_mode, 2))) != 0;
    endproperty
    property p_err_led;
        status_error |-> (status_led_red & status_error) == status_error;
    endproperty
    a_ok: assert property (p_ok) else $error("status flag wrong");
    a_err: assert property (p_err) else $error("error flag wrong");
    a_led: assert property (p_led) else $error("led wrong");
    a_onset1: assert property (p_onset1) else $error("no record ch1");
    a_onset0: assert property (p_onset0) else $error("no record ch0");
    a_fields: assert property (p_fields) else $error("record fields wrong");
    a_src: assert property (p_src) else $error("record without onset");
    a_err_led: assert property (p_err_led) else $error("error without red led");
    c_rec: cover property (diagnostic_event_record_valid);
    c_fault: cover property (single_channel_mode[0] && !status_ok[0]);
    c_err: cover property (status_error[1]);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind encoder_fault_status_input encoder_fault_status_input_asserts #(.CHANNELS(CHANNELS)) u_chk (.*);

// ---- tb/encoder_fault_output_model.sv ----
`timescale 1ns/1ns
module encoder_fault_output_model #(
    parameter int unsigned CHANNELS = 2
) (
    // Fault request per encoder.
    input wire logic [CHANNELS-1:0] fault,
    // Line at the device's status input.
    output logic [CHANNELS-1:0] line
);
    // Open collector: pulled low on fault, else released to the device's pull-up.
    assign line = ~fault;
endmodule

// ---- tb/encoder_fault_status_input_tb_top.sv ----
`timescale 1ns/1ns
module encoder_fault_status_input_tb_top;
    import status_input_pkg::*;
    logic core_clk, arst_n;
    logic [1:0] single_channel_mode, status_pin, overvoltage_detect, fault;
    logic [1:0] status_ok, status_error, status_led_red, diagnostic_event_record_type;
    logic diagnostic_event_record_valid;
    logic [15:0] diagnostic_event_record_text_id;
    logic [0:0] diagnostic_event_record_channel;
    int n_errors = 0;
    int compares = 0;
    encoder_fault_status_input dut (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .single_channel_mode(single_channel_mode),
        .status_pin(status_pin),
        .overvoltage_detect(overvoltage_detect),
        .status_ok(status_ok),
        .status_error(status_error),
        .status_led_red(status_led_red),
        .diagnostic_event_record_valid(diagnostic_event_record_valid),
        .diagnostic_event_record_type(diagnostic_event_record_type),
        .diagnostic_event_record_text_id(diagnostic_event_record_text_id),
        .diagnostic_event_record_channel(diagnostic_event_record_channel)
    );
    encoder_fault_output_model enc (.fault(fault), .line(status_pin));
    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock and a watchdog so a hang still reaches a verdict.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
    task automatic final_report();
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Inputs move on the falling edge; outputs are read just after the rising edge.
    task automatic set(input logic [1:0] m, input logic [1:0] f, input logic [1:0] ov);
        @(negedge core_clk);
        single_channel_mode = m;
        fault = f;
        overvoltage_detect = ov;
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fault();
        set(2'h3, 2'h1, 2'h0);
        step();
        chk(status_ok, 2'h2);
        chk(status_led_red, 2'h1);
        set(2'h3, 2'h0, 2'h0);
        step();
        chk(status_ok, 2'h3);
        chk(status_led_red, 2'h0);
    endtask
    // A disabled channel must ignore both a fault and overvoltage.
    task automatic t_mode();
        set(2'h0, 2'h3, 2'h3);
        step();
        chk({status_ok, status_error, status_led_red, diagnostic_event_record_valid}, 7'h60);
        step();
        chk(diagnostic_event_record_valid, 1'h0);
        set(2'h3, 2'h0, 2'h0);
        step();
    endtask
    task automatic t_ov();
        set(2'h3, 2'h0, 2'h2);
        step();
        chk({status_error, status_led_red}, 4'ha);
        chk(diagnostic_event_record_valid, 1'h1);
        chk(diagnostic_event_record_type, DIAG_TYPE_ERROR);
        chk(diagnostic_event_record_text_id, DIAG_TEXT_OVERVOLT);
        chk(diagnostic_event_record_channel, 1'h1);
        step();
        set(2'h3, 2'h1, 2'h0);
        chk(diagnostic_event_record_valid, 1'h0);
        step();
        chk({status_error, status_led_red}, 4'h1);
        set(2'h3, 2'h0, 2'h3);
        step();
        chk({diagnostic_event_record_valid, diagnostic_event_record_channel}, 2'h2);
        step();
        chk(diagnostic_event_record_valid, 1'h0);
        set(2'h3, 2'h0, 2'h0);
        step();
        chk(status_error, 2'h0);
    endtask
    // A reset in mid-run must drop every output and the held record to the idle picture.
    task automatic t_reset();
        set(2'h3, 2'h1, 2'h2);
        step();
        @(negedge core_clk);
        arst_n = 1'b0;
        #1;
        chk({status_ok, status_error, status_led_red}, 6'h30);
        chk({diagnostic_event_record_valid, diagnostic_event_record_type}, 3'h0);
        chk({diagnostic_event_record_text_id, diagnostic_event_record_channel}, 17'h0);
        set(2'h3, 2'h0, 2'h0);
        @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        arst_n = 1'b0;
        single_channel_mode = 2'h3;
        fault = 2'h0;
        overvoltage_detect = 2'h0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        t_fault();
        t_mode();
        t_ov();
        t_reset();
        t_fault();
        final_report();
    end
endmodule
